// ### common/sep_pkg.sv
package sep_pkg;
    // Opcodes
    localparam logic [7:0] OP_ARM      = 8'h06;
    localparam logic [7:0] OP_DISARM   = 8'h04;
    localparam logic [7:0] OP_STAT_RD  = 8'h05;
    localparam logic [7:0] OP_STAT_WR  = 8'h01;
    localparam logic [7:0] OP_READ     = 8'h03;
    localparam logic [7:0] OP_WRITE    = 8'h02;
    // Status byte field positions
    localparam int ST_LOCK = 7;
    localparam int ST_GHI  = 3;
    localparam int ST_GLO  = 2;
    localparam int ST_WEL  = 1;
    localparam int ST_BUSY = 0;
    // Guarded region lower bounds, per area-guard code
    localparam logic [10:0] GUARD_LO_01 = 11'h600;
    localparam logic [10:0] GUARD_LO_10 = 11'h400;
    localparam logic [10:0] GUARD_LO_11 = 11'h000;
    // Geometry
    localparam int AW         = 11;
    localparam int PAGE_BITS  = 5;
    localparam int FIFO_W     = 19;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_W     = 3;
    typedef enum logic [2:0] {
        SEP_IDLE = 3'b000,
        SEP_CMD  = 3'b001,
        SEP_ADDR = 3'b010,
        SEP_DIN  = 3'b011,
        SEP_DOUT = 3'b100,
        SEP_WAIT = 3'b101
    } sep_state_t;
endpackage

// ### core/sep_spi_slave.sv
// Function
// - Command, address and write bytes arrive MSB first from the first rising edge.
// - Response bytes leave MSB first from the first falling edge after the command.
// - Only the selected device drives the output; unselected ones float it.
// - Inputs captured on rising edges, output updated after falling edges.
// - Instructions are ignored until power-on reset has been released.
// - Reset deselects and clears write latch and busy; guard bits keep values.
// - After reset, selection needs a falling edge on the select line.
// - Select low is active; standby only when deselected and not busy.
// - Pause starts when hold falls while selected and the clock is low.
// - While paused the output floats, inputs are ignored, bit position kept.
// - Deselect during pause resets protocol but keeps latch and busy flags.
// - A complete write command still starts its cycle when deselected during pause.
// - Writes and status writes need a clock count that is a multiple of eight.
// - Modifying commands need the write latch set by the arm command.
// - Select must rise between the final bit's rising edge and the next one.
// - Final bit is the opcode's or last data byte's eighth; reads exempt.
// - Area-guard code 00/01/10/11 blocks none, 600h, 400h, 000h up to 7FFh.
// - Write-protect pin with lock bit freezes the guard bits.
// - While deselected the output is high impedance.
// - An unknown opcode leads to a wait state until deselection.
// - Decode arm, disarm, status fetch, status update, read and write opcodes.
// - Status byte: lock, three zeros, guard hi, guard lo, write latch, busy.
`timescale 1ns/100ps

module sep_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wptr_reg;
    logic [PW-1:0] rptr_reg;
    logic [PW:0]   count_reg;
    logic          push;
    logic          pop;

    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end else begin
            if (push) wptr_reg <= PW'(wptr_reg + 1'b1);
            if (pop) rptr_reg <= PW'(rptr_reg + 1'b1);
            count_reg <= (PW+1)'(count_reg + push - pop);
        end
    end
endmodule

module sep_spi_slave (
    // System
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    // Serial pins
    input  wire logic                    spi_clk,
    input  wire logic                    spi_sel_n,
    input  wire logic                    spi_din,
    input  wire logic                    spi_hold_n,
    input  wire logic                    spi_wp_n,
    output logic                         spi_dout,
    output logic                         spi_dout_oe,
    // Array write stream
    output logic                         wr_valid,
    input  wire logic                    wr_ready,
    output logic [sep_pkg::AW-1:0]       wr_addr,
    output logic [7:0]                   wr_byte,
    output logic                         wr_commit,
    output logic                         wr_abort,
    // Array read
    output logic                         rd_req,
    output logic [sep_pkg::AW-1:0]       rd_addr,
    input  wire logic [7:0]              rd_data,
    // Internal cycle and nonvolatile store
    input  wire logic                    cycle_done,
    output logic                         stat_commit,
    input  wire logic                    nv_load,
    input  wire logic [2:0]              nv_bits_in,
    output logic [2:0]                   nv_bits_out,
    // Status
    output logic                         standby,
    output logic [7:0]                   status_byte
);
    import sep_pkg::*;

    logic [SYNC_W-1:0] clk_q, sel_q, din_q, hold_q, wp_q;
    logic clk_lvl_reg, sel_lvl_reg, hold_lvl_reg, wp_lvl_reg;
    logic clk_rise, clk_fall, sel_fall, sel_rise, go_rise, go_fall;
    logic active_reg, paused_reg, end_ok_reg, bad_reg, pushed_reg;
    logic wel_reg, busy_reg, stat_pend_reg;
    logic lock_reg, ghi_reg, glo_reg;
    logic [7:0] stat_new_reg, op_reg, rx_reg, tx_reg, nxt_reg;
    logic [7:0] rx_byte;
    logic [2:0] bit_cnt_reg, fbit_reg;
    logic [2:0] addr_hi_reg;
    logic       addr_first_reg, rd_pend_reg, rd_first_reg, dout_reg, oe_reg;
    logic [AW-1:0] addr_reg;
    logic       byte_done, exec_ok, fifo_in_ready, push;
    sep_state_t state_reg;

    function automatic logic guarded(input logic [AW-1:0] a, input logic hi, input logic lo);
        case ({hi, lo})
            2'b01:   guarded = (a >= GUARD_LO_01);
            2'b10:   guarded = (a >= GUARD_LO_10);
            2'b11:   guarded = (a >= GUARD_LO_11);
            default: guarded = 1'b0;
        endcase
    endfunction

    // Three-stage sampling; a level only moves once stages two and three agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clk_q  <= '0;
            // Select starts as low, so a pin held low through reset never reads as a fall
            sel_q  <= '0;
            din_q  <= '0;
            hold_q <= '1;
            wp_q   <= '1;
        end else begin
            clk_q  <= {clk_q[1:0], spi_clk};
            sel_q  <= {sel_q[1:0], spi_sel_n};
            din_q  <= {din_q[1:0], spi_din};
            hold_q <= {hold_q[1:0], spi_hold_n};
            wp_q   <= {wp_q[1:0], spi_wp_n};
        end
    end

    // Parked clock level is unknown, so start from whatever settles first
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clk_lvl_reg  <= 1'b0;
            sel_lvl_reg  <= 1'b0;
            hold_lvl_reg <= 1'b1;
            wp_lvl_reg   <= 1'b1;
        end else begin
            if (clk_q[1] == clk_q[2]) clk_lvl_reg <= clk_q[2];
            if (sel_q[1] == sel_q[2]) sel_lvl_reg <= sel_q[2];
            if (hold_q[1] == hold_q[2]) hold_lvl_reg <= hold_q[2];
            if (wp_q[1] == wp_q[2]) wp_lvl_reg <= wp_q[2];
        end
    end

    assign clk_rise = (clk_q[1] == clk_q[2]) & clk_q[2] & ~clk_lvl_reg;
    assign clk_fall = (clk_q[1] == clk_q[2]) & ~clk_q[2] & clk_lvl_reg;
    assign sel_fall = (sel_q[1] == sel_q[2]) & ~sel_q[2] & sel_lvl_reg;
    assign sel_rise = (sel_q[1] == sel_q[2]) & sel_q[2] & ~sel_lvl_reg;
    assign go_rise  = active_reg & ~paused_reg & clk_rise;
    assign go_fall  = active_reg & ~paused_reg & clk_fall;
    assign rx_byte  = {rx_reg[6:0], din_q[2]};
    assign byte_done = go_rise & (bit_cnt_reg == 3'h7);

    // Selection is edge-armed: a low select held through reset never selects
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            active_reg <= 1'b0;
        end else if (sel_rise) begin
            active_reg <= 1'b0;
        end else if (sel_fall) begin
            active_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            paused_reg <= 1'b0;
        end else if (!active_reg || sel_rise) begin
            paused_reg <= 1'b0;
        end else if (!paused_reg && !hold_lvl_reg && !clk_lvl_reg) begin
            paused_reg <= 1'b1;
        end else if (paused_reg && hold_lvl_reg) begin
            paused_reg <= 1'b0;
        end
    end

    // Deselect executes only right after a whole byte with no further clock
    assign exec_ok = sel_rise & active_reg & end_ok_reg & ~bad_reg;
    assign push    = (state_reg == SEP_DIN) & byte_done & (op_reg == OP_WRITE);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg      <= SEP_IDLE;
            bit_cnt_reg    <= '0;
            rx_reg         <= '0;
            op_reg         <= '0;
            end_ok_reg     <= 1'b0;
            bad_reg        <= 1'b0;
            pushed_reg     <= 1'b0;
            addr_first_reg <= 1'b0;
            addr_hi_reg    <= '0;
            stat_new_reg   <= '0;
        end else if (!active_reg || sel_rise) begin
            state_reg   <= SEP_IDLE;
            bit_cnt_reg <= '0;
            end_ok_reg  <= 1'b0;
            bad_reg     <= 1'b0;
            pushed_reg  <= 1'b0;
        end else if (go_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_reg      <= rx_byte;
            end_ok_reg  <= 1'b0;
            if (state_reg == SEP_IDLE) state_reg <= SEP_CMD;
            if (byte_done) begin
                case (state_reg)
                    SEP_IDLE, SEP_CMD: begin
                        op_reg         <= rx_byte;
                        addr_first_reg <= 1'b1;
                        case (rx_byte)
                            OP_ARM, OP_DISARM: begin
                                end_ok_reg <= 1'b1;
                                state_reg  <= SEP_WAIT;
                            end
                            OP_STAT_RD: state_reg <= SEP_DOUT;
                            OP_READ:    state_reg <= SEP_ADDR;
                            OP_STAT_WR: state_reg <= (wel_reg && !busy_reg) ? SEP_DIN : SEP_WAIT;
                            OP_WRITE:   state_reg <= (wel_reg && !busy_reg) ? SEP_ADDR : SEP_WAIT;
                            default:    state_reg <= SEP_WAIT;
                        endcase
                    end
                    SEP_ADDR: begin
                        addr_first_reg <= 1'b0;
                        addr_hi_reg    <= rx_byte[2:0];
                        if (!addr_first_reg) begin
                            state_reg <= (op_reg == OP_READ) ? SEP_DOUT : SEP_DIN;
                        end
                    end
                    SEP_DIN: begin
                        end_ok_reg <= 1'b1;
                        if (op_reg == OP_STAT_WR) begin
                            stat_new_reg <= rx_byte;
                            state_reg    <= SEP_WAIT;
                        end else begin
                            pushed_reg <= 1'b1;
                            // Full buffer or guarded byte spoils the whole command
                            if (!fifo_in_ready || guarded(addr_reg, ghi_reg, glo_reg)) begin
                                bad_reg <= 1'b1;
                            end
                        end
                    end
                    default: state_reg <= state_reg;
                endcase
            end
        end
    end

    // Array address; writes wrap within the page, reads run through the array
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            addr_reg <= '0;
        end else if (active_reg && state_reg == SEP_ADDR && byte_done && !addr_first_reg) begin
            addr_reg <= {addr_hi_reg, rx_byte};
        end else if (push) begin
            addr_reg[PAGE_BITS-1:0] <= addr_reg[PAGE_BITS-1:0] + 1'b1;
        end else if (rd_req) begin
            addr_reg <= addr_reg + 11'h001;
        end
    end

    // Read side: first byte fetched at address end, later ones one byte ahead
    assign rd_addr = addr_reg;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_req       <= 1'b0;
            rd_pend_reg  <= 1'b0;
            rd_first_reg <= 1'b0;
        end else begin
            rd_req      <= 1'b0;
            rd_pend_reg <= rd_req;
            if (active_reg && state_reg == SEP_ADDR && byte_done && !addr_first_reg
                && op_reg == OP_READ) begin
                rd_req       <= 1'b1;
                rd_first_reg <= 1'b1;
            end else if (go_fall && state_reg == SEP_DOUT && op_reg == OP_READ
                         && fbit_reg == 3'h0) begin
                rd_req       <= 1'b1;
                rd_first_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            tx_reg   <= '0;
            nxt_reg  <= '0;
            fbit_reg <= '0;
            dout_reg <= 1'b0;
        end else if (!active_reg) begin
            fbit_reg <= '0;
        end else if (state_reg == SEP_CMD && byte_done) begin
            tx_reg   <= status_byte;
            fbit_reg <= '0;
        end else if (rd_pend_reg && rd_first_reg) begin
            tx_reg <= rd_data;
        end else if (rd_pend_reg) begin
            nxt_reg <= rd_data;
        end else if (go_fall && state_reg == SEP_DOUT) begin
            dout_reg <= tx_reg[7];
            fbit_reg <= fbit_reg + 3'h1;
            if (fbit_reg == 3'h7) begin
                tx_reg <= (op_reg == OP_READ) ? nxt_reg : status_byte;
            end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= active_reg & ~sel_rise & ~paused_reg & (state_reg == SEP_DOUT);
        end
    end
    assign spi_dout    = dout_reg;
    assign spi_dout_oe = oe_reg;

    // Volatile flags; a cycle end never swallows a latch set in the same clock
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wel_reg       <= 1'b0;
            busy_reg      <= 1'b0;
            stat_pend_reg <= 1'b0;
            wr_commit     <= 1'b0;
            wr_abort      <= 1'b0;
            stat_commit   <= 1'b0;
        end else begin
            wr_commit   <= 1'b0;
            wr_abort    <= 1'b0;
            stat_commit <= 1'b0;
            if (cycle_done) begin
                busy_reg      <= 1'b0;
                wel_reg       <= 1'b0;
                stat_pend_reg <= 1'b0;
            end
            if (exec_ok) begin
                case (op_reg)
                    OP_ARM:    wel_reg <= 1'b1;
                    OP_DISARM: wel_reg <= 1'b0;
                    OP_STAT_WR: begin
                        if (!(lock_reg && !wp_lvl_reg)) begin
                            busy_reg      <= 1'b1;
                            stat_pend_reg <= 1'b1;
                            stat_commit   <= 1'b1;
                        end
                    end
                    OP_WRITE: begin
                        busy_reg  <= 1'b1;
                        wr_commit <= 1'b1;
                    end
                    default: busy_reg <= busy_reg;
                endcase
            end else if (sel_rise && pushed_reg) begin
                wr_abort <= 1'b1;
            end
        end
    end

    // Nonvolatile bits are not touched by reset; the store restores them
    always_ff @(posedge clk_sys) begin
        if (nv_load) begin
            {lock_reg, ghi_reg, glo_reg} <= nv_bits_in;
        end else if (cycle_done && stat_pend_reg) begin
            lock_reg <= stat_new_reg[ST_LOCK];
            ghi_reg  <= stat_new_reg[ST_GHI];
            glo_reg  <= stat_new_reg[ST_GLO];
        end
    end

    assign nv_bits_out = {lock_reg, ghi_reg, glo_reg};
    assign status_byte = {lock_reg, 3'b000, ghi_reg, glo_reg, wel_reg, busy_reg};
    assign standby     = ~active_reg & ~busy_reg;

    sep_fifo #(
        .W     (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (push & ~guarded(addr_reg, ghi_reg, glo_reg)),
        .in_ready  (fifo_in_ready),
        .in_data   ({addr_reg, rx_byte}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_addr, wr_byte})
    );

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    deselect_float_a: assert property (!active_reg |=> !spi_dout_oe)
        else $error("output driven while deselected");
    pause_float_a: assert property (paused_reg |=> !spi_dout_oe)
        else $error("output driven while paused");
    pause_keeps_bits_a: assert property (paused_reg && $past(paused_reg) && active_reg |-> $stable(bit_cnt_reg))
        else $error("bit position moved while paused");
    idle_clear_a: assert property (!active_reg |=> bit_cnt_reg == 3'h0)
        else $error("bit counter not cleared while deselected");
    commit_aligned_a: assert property (wr_commit |-> $past(bit_cnt_reg) == 3'h0 && $past(wel_reg))
        else $error("write committed off a byte boundary");
    arm_sets_a: assert property (exec_ok && op_reg == OP_ARM |=> wel_reg)
        else $error("arm command did not set the latch");
    guard_push_a: assert property (u_fifo.push |-> !guarded(addr_reg, ghi_reg, glo_reg))
        else $error("guarded byte entered the buffer");
    lock_blocks_a: assert property (stat_commit |-> !($past(lock_reg) && !$past(wp_lvl_reg)))
        else $error("status update despite hardware lock");
    unknown_wait_a: assert property (state_reg == SEP_WAIT && active_reg && !sel_rise |=> state_reg == SEP_WAIT)
        else $error("wait state left while selected");
    late_clock_a: assert property (go_rise && !byte_done |=> !end_ok_reg)
        else $error("command still armed after a stray clock");

    read_c: cover property (state_reg == SEP_DOUT && op_reg == OP_READ ##[1:200] go_fall);
    status_c: cover property (stat_commit);
    write_c: cover property (wr_commit);
    pause_c: cover property (paused_reg ##1 !active_reg);
endmodule

// ### dv/sep_spi_master.sv
`timescale 1ns/100ps
module sep_spi_master (
    // Serial pins toward the device
    output logic      spi_clk,
    output logic      spi_sel_n,
    output logic      spi_din,
    output logic      spi_hold_n,
    // Resolved answer line
    input  wire logic spi_dout_w
);
    localparam time HALF = 24ns;
    logic cpol = 1'b0;
    initial begin
        spi_clk    = 1'b0;
        spi_sel_n  = 1'b1;
        spi_din    = 1'b0;
        spi_hold_n = 1'b1;
    end
    task automatic set_mode(input logic m);
        cpol = m;
        spi_clk = m;
        #(4*HALF);
    endtask
    task automatic sel();
        spi_sel_n = 1'b0;
        #(2*HALF);
    endtask
    task automatic bits(input logic [63:0] v, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = n - 1; i >= 0; i--) begin
            spi_clk = 1'b0;
            spi_din = v[i];
            #HALF;
            spi_clk = 1'b1;
            q = {q[6:0], spi_dout_w};
            #HALF;
        end
    endtask
    task automatic desel();
        // Park the clock before release so no stray rise follows the last bit
        if (!cpol) begin
            spi_clk = 1'b0;
            #HALF;
        end
        spi_sel_n = 1'b1;
        spi_din = ~spi_din;
        #(4*HALF);
    endtask
    task automatic pause(input logic h);
        // Hold only moves with the clock low, so no pulse is split
        spi_clk = 1'b0;
        #HALF;
        spi_hold_n = h;
        #(2*HALF);
    endtask
endmodule

// ### dv/spi_eeprom_bus_protocol_tb_top.sv
`timescale 1ns/100ps
module spi_eeprom_bus_protocol_tb_top;
    import sep_pkg::*;
    logic          clk_sys = 1'b0, reset = 1'b1, wr_ready = 1'b1, cycle_done = 1'b0;
    logic          nv_load = 1'b0, spi_wp_n = 1'b1;
    logic [2:0]    nv_bits_in = 3'b000, nv_bits_out;
    logic          spi_clk, spi_sel_n, spi_din, spi_hold_n, spi_dout, spi_dout_oe;
    logic          wr_valid, wr_commit, wr_abort, rd_req, stat_commit, standby;
    logic [AW-1:0] wr_addr, rd_addr, last_addr;
    logic [7:0]    wr_byte, rd_data, status_byte, last_byte, q;
    wire           dout_w = spi_dout_oe ? spi_dout : 1'bz;
    int            error_cnt = 0, n_checks = 0, n_wc = 0, n_wa = 0, n_sc = 0;

    always #2 clk_sys = ~clk_sys;
    // Array model takes the address with the request and answers one cycle later
    always @(posedge clk_sys) begin
        if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h5a;
    end
    always @(posedge clk_sys) begin
        if (wr_commit) n_wc++;
        if (wr_abort) n_wa++;
        if (stat_commit) n_sc++;
        if (wr_valid && wr_ready) {last_addr, last_byte} <= {wr_addr, wr_byte};
    end

    sep_spi_slave i_sep_spi_slave (.clk_sys, .reset, .spi_clk, .spi_sel_n, .spi_din, .spi_hold_n,
        .spi_wp_n, .spi_dout, .spi_dout_oe, .wr_valid, .wr_ready, .wr_addr, .wr_byte, .wr_commit,
        .wr_abort, .rd_req, .rd_addr, .rd_data, .cycle_done, .stat_commit, .nv_load, .nv_bits_in,
        .nv_bits_out, .standby, .status_byte);
    sep_spi_master i_sep_spi_master (.spi_clk, .spi_sel_n, .spi_din, .spi_hold_n, .spi_dout_w(dout_w));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (12) @(posedge clk_sys);
        #1;
    endtask
    task automatic cmd(input logic [63:0] v, input int n);
        i_sep_spi_master.sel();
        i_sep_spi_master.bits(v, n, q);
        i_sep_spi_master.desel();
        settle();
    endtask
    task automatic done();
        @(posedge clk_sys) #1 cycle_done = 1'b1;
        @(posedge clk_sys) #1 cycle_done = 1'b0;
        settle();
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        #1 reset = 1'b0;
        @(posedge clk_sys) #1 nv_load = 1'b1;
        @(posedge clk_sys) #1 nv_load = 1'b0;
        settle();
        chk8(status_byte, 8'h00);
        chk8({7'h00, standby}, 8'h01);
        cmd(64'h06, 8);
        chk8(status_byte, 8'h02);
        cmd(64'h0500, 16);
        chk8(q, 8'h02);
        chk8({7'h00, spi_dout_oe}, 8'h00);
        i_sep_spi_master.set_mode(1'b1);
        cmd(64'h0500, 16);
        chk8(q, 8'h02);
        i_sep_spi_master.set_mode(1'b0);
        cmd(64'h04, 8);
        chk8(status_byte, 8'h00);
        cmd(64'h020010a5, 32);
        chk8(8'(n_wc), 8'h00);
        cmd(64'h06, 8);
        cmd({8'h02, 16'h0010, 8'ha5, 1'b0}, 33);
        chk8(8'(n_wc), 8'h00);
        chk8(8'(n_wa), 8'h01);
        cmd(64'h06, 8);
        cmd(64'h020010a5, 32);
        chk8(8'(n_wc), 8'h01);
        chk8(status_byte, 8'h03);
        chk8({7'h00, standby}, 8'h00);
        chk8(last_byte, 8'ha5);
        chk8(last_addr[7:0], 8'h10);
        done();
        chk8(status_byte, 8'h00);
        cmd(64'h06, 8);
        cmd(64'h018c, 16);
        chk8(8'(n_sc), 8'h01);
        done();
        chk8(status_byte, 8'h8c);
        cmd(64'h06, 8);
        cmd(64'h02000011, 32);
        chk8(8'(n_wa), 8'h02);
        @(posedge clk_sys) #1 spi_wp_n = 1'b0;
        cmd(64'h06, 8);
        cmd(64'h0104, 16);
        chk8(8'(n_sc), 8'h01);
        @(posedge clk_sys) #1 spi_wp_n = 1'b1;
        cmd(64'h06, 8);
        cmd(64'h0104, 16);
        chk8(8'(n_sc), 8'h02);
        done();
        chk8(status_byte, 8'h04);
        cmd(64'h06, 8);
        cmd(64'h0205ff3c, 32);
        chk8(8'(n_wc), 8'h02);
        done();
        cmd(64'h06, 8);
        cmd(64'h0206003c, 32);
        chk8(8'(n_wa), 8'h03);
        // Stalled array side: the fifth byte overruns the four-word buffer
        @(posedge clk_sys) #1 wr_ready = 1'b0;
        cmd(64'h06, 8);
        cmd({8'h02, 16'h0000, 40'h0102030405}, 64);
        chk8(8'(n_wa), 8'h04);
        @(posedge clk_sys) #1 wr_ready = 1'b1;
        settle();
        chk8({7'h00, wr_valid}, 8'h00);
        // A pause splits an arm command; clocks during the pause must not count
        cmd(64'h04, 8);
        i_sep_spi_master.sel();
        i_sep_spi_master.bits(64'h0, 4, q);
        i_sep_spi_master.pause(1'b0);
        i_sep_spi_master.bits(64'hf, 4, q);
        i_sep_spi_master.pause(1'b1);
        i_sep_spi_master.bits(64'h6, 4, q);
        i_sep_spi_master.desel();
        settle();
        chk8(status_byte, 8'h06);
        i_sep_spi_master.sel();
        i_sep_spi_master.bits(64'h020010a5, 32, q);
        i_sep_spi_master.pause(1'b0);
        i_sep_spi_master.desel();
        i_sep_spi_master.pause(1'b1);
        settle();
        chk8(8'(n_wc), 8'h03);
        i_sep_spi_master.sel();
        i_sep_spi_master.bits(64'h0, 4, q);
        i_sep_spi_master.pause(1'b0);
        i_sep_spi_master.desel();
        i_sep_spi_master.pause(1'b1);
        settle();
        chk8(status_byte, 8'h07);
        cmd(64'h04, 8);
        chk8(status_byte, 8'h05);
        done();
        cmd(64'h03012300, 32);
        chk8(q, 8'h79);
        cmd(64'h0301230000, 40);
        chk8(q, 8'h7e);
        chk8({5'h00, nv_bits_out}, 8'h01);
        stop_test();
    end
endmodule
